// >>> crf_pkg.sv
// Notes on behaviour
// RL1 - Four 16-bit data registers, byte halves low two
// RL2 - Third/first and fourth/second pair as 32 bits
// RL3 - Two 16-bit address registers, pair 32 bits
// RL4 - Bank flag selects one of two register banks
// RL5 - 16-bit frame base and static base registers
// RL6 - 20-bit interrupt vector table base register
// RL7 - 20-bit program counter holds next instruction
// RL8 - Stack select: 0 interrupt SP, 1 user SP
// RL9 - Stack select cleared on hardware or low swint
// RL10 - Processor flag register is 11 bits wide
// RL11 - Carry flag stores carry, borrow, shifted bit
// RL12 - Software keeps debug flag at zero
// RL13 - Zero flag set when result is zero
// RL14 - Sign flag set when result negative
// RL15 - Overflow flag set when operation overflows
// RL16 - Interrupt enable gates maskable, cleared on accept
// RL17 - 3-bit priority level, accept only higher requests
// RL18 - Reserved flag bit written zero, reads undefined
// RL19 - Decode 1-Mbyte space 00000h to FFFFFh
// RL20 - Peripheral registers at 00000h to 002FFh
// RL21 - Internal RAM from 00400h upward
// RL22 - Program ROM ends at 0FFFFh, grows downward
// RL23 - Fixed vector table at 0FFDCh to 0FFFFh
// RL24 - Data flash at 02400h to 02BFFh
// RL25 - Only data, address, frame registers are banked
`default_nettype none
package crf_pkg;

  // ==========================================================
  // Register indices (also Avalon word addresses)
  localparam logic [3:0] IDX_DATA0 = 4'h0;
  localparam logic [3:0] IDX_DATA1 = 4'h1;
  localparam logic [3:0] IDX_DATA2 = 4'h2;
  localparam logic [3:0] IDX_DATA3 = 4'h3;
  localparam logic [3:0] IDX_ADDR0 = 4'h4;
  localparam logic [3:0] IDX_ADDR1 = 4'h5;
  localparam logic [3:0] IDX_FRAME = 4'h6;
  localparam logic [3:0] IDX_VECT = 4'h7;
  localparam logic [3:0] IDX_PC = 4'h8;
  localparam logic [3:0] IDX_USP = 4'h9;
  localparam logic [3:0] IDX_ISP = 4'ha;
  localparam logic [3:0] IDX_SB = 4'hb;
  localparam logic [3:0] IDX_FLAGS = 4'hc;
  localparam int BANK_REGS = 7;

  // ==========================================================
  // Flag layout
  localparam int FLG_W = 11;
  localparam int FLG_C = 0;
  localparam int FLG_D = 1;
  localparam int FLG_Z = 2;
  localparam int FLG_S = 3;
  localparam int FLG_B = 4;
  localparam int FLG_O = 5;
  localparam int FLG_I = 6;
  localparam int FLG_U = 7;
  localparam int FLG_IPL_LSB = 8;
  localparam int VIEW_IPL_LSB = 12;
  localparam int VIEW_RSV = 15;

  // ==========================================================
  // Reset values
  localparam logic [10:0] FLG_RST = 11'h000;
  localparam logic [15:0] REG16_RST = 16'h0000;
  localparam logic [19:0] REG20_RST = 20'h00000;

  // ==========================================================
  // Memory map
  localparam logic [19:0] SFR_BASE = 20'h00000;
  localparam logic [19:0] SFR_LAST = 20'h002ff;
  localparam logic [19:0] RAM_BASE = 20'h00400;
  localparam logic [19:0] ROM_LAST = 20'h0ffff;
  localparam logic [19:0] VECT_BASE = 20'h0ffdc;
  localparam logic [19:0] DFL_BASE = 20'h02400;
  localparam logic [19:0] DFL_LAST = 20'h02bff;
  localparam logic [5:0] SWINT_HW_LAST = 6'h1f;

  typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} crf_size_t;

endpackage
`default_nettype wire

// >>> crf_cpu_regs.sv
// The register offsets and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
module crf_cpu_regs #(
  parameter int RAM_BYTES = 1024,
  parameter int ROM_BYTES = 16384,
  parameter bit HAS_DFLASH = 1'b1
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // Avalon-MM slave
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Core register port
  input wire logic i_core_wr_en,
  input wire logic [3:0] i_core_wr_sel,
  input wire crf_pkg::crf_size_t i_core_wr_size,
  input wire logic i_core_wr_high,
  input wire logic [31:0] i_core_wr_data,
  input wire logic [3:0] i_core_rd_sel,
  input wire crf_pkg::crf_size_t i_core_rd_size,
  input wire logic i_core_rd_high,
  output logic [31:0] o_core_rd_data,
  // ALU results, enables in order carry, zero, sign, overflow
  input wire logic [3:0] i_alu_flag_we,
  input wire logic i_alu_carry,
  input wire logic [15:0] i_alu_result,
  input wire logic i_alu_result_byte,
  input wire logic i_alu_overflow,
  // Interrupts
  input wire logic i_irq_req,
  input wire logic i_irq_nonmask,
  input wire logic [2:0] i_irq_level,
  output logic o_irq_take,
  input wire logic i_swint_exec,
  input wire logic [5:0] i_swint_num,
  // Core state
  output logic [19:0] o_pc,
  output logic [19:0] o_vector_base,
  output logic [15:0] o_active_sp,
  output logic [15:0] o_static_base,
  output logic [15:0] o_frame_base,
  output logic [10:0] o_flags,
  // Address decode
  input wire logic [19:0] i_map_addr,
  output logic o_map_sfr,
  output logic o_map_ram,
  output logic o_map_dflash,
  output logic o_map_rom,
  output logic o_map_vector,
  output logic o_map_none
);

  localparam logic [19:0] RAM_LAST = 20'(crf_pkg::RAM_BASE + RAM_BYTES - 1);
  localparam logic [19:0] ROM_FIRST = 20'(crf_pkg::ROM_LAST - ROM_BYTES + 1);

  // ==========================================================
  // Storage
  logic [15:0] bank_ff [2][crf_pkg::BANK_REGS];
  logic [19:0] pc_ff;
  logic [19:0] vect_ff;
  logic [15:0] usp_ff;
  logic [15:0] isp_ff;
  logic [15:0] sb_ff;
  logic [10:0] flg_ff;
  logic bank;
  logic ack_ff;
  logic bus_wr;
  logic [31:0] w_msk [13];
  logic [31:0] w_dat [13];
  logic [10:0] nxt_flg;
  logic sw_clr_stack;
  logic [31:0] core_lo_view;
  logic [31:0] core_hi_view;

  assign bank = flg_ff[crf_pkg::FLG_B]; // RL4

  function automatic logic [31:0] reg_view(input logic [3:0] idx);
    reg_view = '0;
    if (idx < 4'(crf_pkg::BANK_REGS)) begin
      reg_view = {16'h0000, bank_ff[bank][idx[2:0]]}; // RL4
    end else begin
      unique case (idx)
        crf_pkg::IDX_VECT: reg_view = {12'h000, vect_ff};
        crf_pkg::IDX_PC: reg_view = {12'h000, pc_ff};
        crf_pkg::IDX_USP: reg_view = {16'h0000, usp_ff};
        crf_pkg::IDX_ISP: reg_view = {16'h0000, isp_ff};
        crf_pkg::IDX_SB: reg_view = {16'h0000, sb_ff};
        // Reserved bit reads back as zero
        crf_pkg::IDX_FLAGS: reg_view = {17'h00000, flg_ff[10:8], 4'h0, flg_ff[7:0]}; // RL18
        default: reg_view = '0;
      endcase
    end
  endfunction

  // ==========================================================
  // Avalon slave: one wait state on every access
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_ff;
  assign bus_wr = i_avs_write & ack_ff;

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= (i_avs_read | i_avs_write) & ~ack_ff;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_avs_readdata <= '0;
    end else if (i_avs_read & ~ack_ff) begin
      o_avs_readdata <= reg_view(i_avs_address);
    end
  end

  // ==========================================================
  // Write merge: core port wins over the bus in the same cycle
  always_comb begin
    for (int i = 0; i < 13; i++) begin
      w_msk[i] = '0;
      w_dat[i] = '0;
    end
    if (bus_wr && i_avs_address <= crf_pkg::IDX_FLAGS) begin
      w_msk[i_avs_address] = {12'h000, {4{i_avs_byteenable[2]}},
        {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
      w_dat[i_avs_address] = i_avs_writedata;
    end
    if (i_core_wr_en && i_core_wr_sel <= crf_pkg::IDX_FLAGS) begin
      unique case (i_core_wr_size)
        crf_pkg::SZ_BYTE: begin
          if (i_core_wr_sel <= crf_pkg::IDX_DATA1) begin
            w_msk[i_core_wr_sel] = i_core_wr_high ? 32'h0000ff00 : 32'h000000ff; // RL1
            w_dat[i_core_wr_sel] = {16'h0000, i_core_wr_data[7:0], i_core_wr_data[7:0]};
          end
        end
        crf_pkg::SZ_WORD: begin
          w_msk[i_core_wr_sel] = 32'h000fffff;
          w_dat[i_core_wr_sel] = i_core_wr_data;
        end
        crf_pkg::SZ_LONG: begin
          w_msk[i_core_wr_sel] = 32'h000fffff;
          w_dat[i_core_wr_sel] = i_core_wr_data;
          // Upper half goes to the partner register
          if (i_core_wr_sel <= crf_pkg::IDX_DATA1) begin
            w_msk[i_core_wr_sel + 4'h2] = 32'h0000ffff; // RL2
            w_dat[i_core_wr_sel + 4'h2] = {16'h0000, i_core_wr_data[31:16]};
          end else if (i_core_wr_sel == crf_pkg::IDX_ADDR0) begin
            w_msk[crf_pkg::IDX_ADDR1] = 32'h0000ffff; // RL3
            w_dat[crf_pkg::IDX_ADDR1] = {16'h0000, i_core_wr_data[31:16]};
          end
        end
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Banked registers: data, address, frame
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int b = 0; b < 2; b++) begin
        for (int i = 0; i < crf_pkg::BANK_REGS; i++) begin
          bank_ff[b][i] <= crf_pkg::REG16_RST;
        end
      end
    end else begin
      for (int i = 0; i < crf_pkg::BANK_REGS; i++) begin
        bank_ff[bank][i] <= (bank_ff[bank][i] & ~w_msk[i][15:0])
          | (w_dat[i][15:0] & w_msk[i][15:0]); // RL4 RL1 RL3 RL5 RL25
      end
    end
  end

  // ==========================================================
  // Shared registers
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pc_ff <= crf_pkg::REG20_RST;
      vect_ff <= crf_pkg::REG20_RST;
      usp_ff <= crf_pkg::REG16_RST;
      isp_ff <= crf_pkg::REG16_RST;
      sb_ff <= crf_pkg::REG16_RST;
    end else begin
      pc_ff <= (pc_ff & ~w_msk[crf_pkg::IDX_PC][19:0])
        | (w_dat[crf_pkg::IDX_PC][19:0] & w_msk[crf_pkg::IDX_PC][19:0]); // RL7
      vect_ff <= (vect_ff & ~w_msk[crf_pkg::IDX_VECT][19:0])
        | (w_dat[crf_pkg::IDX_VECT][19:0] & w_msk[crf_pkg::IDX_VECT][19:0]); // RL6
      usp_ff <= (usp_ff & ~w_msk[crf_pkg::IDX_USP][15:0])
        | (w_dat[crf_pkg::IDX_USP][15:0] & w_msk[crf_pkg::IDX_USP][15:0]); // RL8
      isp_ff <= (isp_ff & ~w_msk[crf_pkg::IDX_ISP][15:0])
        | (w_dat[crf_pkg::IDX_ISP][15:0] & w_msk[crf_pkg::IDX_ISP][15:0]); // RL8
      sb_ff <= (sb_ff & ~w_msk[crf_pkg::IDX_SB][15:0])
        | (w_dat[crf_pkg::IDX_SB][15:0] & w_msk[crf_pkg::IDX_SB][15:0]); // RL5 RL25
    end
  end

  // ==========================================================
  // Flags: hardware events override explicit writes
  assign o_irq_take = i_irq_req & (i_irq_nonmask
    | (flg_ff[crf_pkg::FLG_I] & (i_irq_level > flg_ff[10:8]))); // RL16 RL17
  assign sw_clr_stack = i_swint_exec & (i_swint_num <= crf_pkg::SWINT_HW_LAST);

  always_comb begin
    nxt_flg = flg_ff;
    // Flag view: bits 7:0 direct, priority level at 14:12, bit 15 dropped
    for (int i = 0; i < 8; i++) begin
      if (w_msk[crf_pkg::IDX_FLAGS][i]) begin
        nxt_flg[i] = w_dat[crf_pkg::IDX_FLAGS][i];
      end
    end
    for (int i = 0; i < 3; i++) begin
      if (w_msk[crf_pkg::IDX_FLAGS][crf_pkg::VIEW_IPL_LSB + i]) begin
        nxt_flg[crf_pkg::FLG_IPL_LSB + i] = w_dat[crf_pkg::IDX_FLAGS][crf_pkg::VIEW_IPL_LSB + i];
      end
    end
    if (i_alu_flag_we[0]) begin
      nxt_flg[crf_pkg::FLG_C] = i_alu_carry; // RL11
    end
    if (i_alu_flag_we[1]) begin
      nxt_flg[crf_pkg::FLG_Z] = i_alu_result_byte ? (i_alu_result[7:0] == 8'h00)
        : (i_alu_result == 16'h0000); // RL13
    end
    if (i_alu_flag_we[2]) begin
      nxt_flg[crf_pkg::FLG_S] = i_alu_result_byte ? i_alu_result[7]
        : i_alu_result[15]; // RL14
    end
    if (i_alu_flag_we[3]) begin
      nxt_flg[crf_pkg::FLG_O] = i_alu_overflow; // RL15
    end
    if (o_irq_take) begin
      nxt_flg[crf_pkg::FLG_I] = 1'b0; // RL16
      nxt_flg[crf_pkg::FLG_U] = 1'b0; // RL9
    end
    if (sw_clr_stack) begin
      nxt_flg[crf_pkg::FLG_U] = 1'b0; // RL9
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      flg_ff <= crf_pkg::FLG_RST;
    end else begin
      flg_ff <= nxt_flg; // RL10
    end
  end

  // ==========================================================
  // Core read port, one cycle latency
  // Views held in nets: a function result cannot be part-selected
  always_comb begin
    core_lo_view = reg_view(i_core_rd_sel);
    core_hi_view = reg_view(crf_pkg::IDX_ADDR1);
    if (i_core_rd_sel <= crf_pkg::IDX_DATA1) begin
      core_hi_view = reg_view(i_core_rd_sel + 4'h2); // RL2
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_core_rd_data <= '0;
    end else begin
      unique case (i_core_rd_size)
        crf_pkg::SZ_BYTE: begin
          o_core_rd_data <= {24'h000000, i_core_rd_high ? core_lo_view[15:8]
            : core_lo_view[7:0]}; // RL1
        end
        crf_pkg::SZ_LONG: begin
          if (i_core_rd_sel <= crf_pkg::IDX_DATA1) begin
            o_core_rd_data <= {core_hi_view[15:0], core_lo_view[15:0]}; // RL2
          end else if (i_core_rd_sel == crf_pkg::IDX_ADDR0) begin
            o_core_rd_data <= {core_hi_view[15:0], core_lo_view[15:0]}; // RL3
          end else begin
            o_core_rd_data <= core_lo_view;
          end
        end
        default: o_core_rd_data <= core_lo_view;
      endcase
    end
  end

  assign o_pc = pc_ff;
  assign o_vector_base = vect_ff;
  assign o_active_sp = flg_ff[crf_pkg::FLG_U] ? usp_ff : isp_ff; // RL8
  assign o_static_base = sb_ff;
  assign o_frame_base = bank_ff[bank][crf_pkg::IDX_FRAME[2:0]];
  assign o_flags = flg_ff;

  // ==========================================================
  // Address decode, registered; full 20-bit space
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_map_sfr <= 1'b0;
      o_map_ram <= 1'b0;
      o_map_dflash <= 1'b0;
      o_map_rom <= 1'b0;
      o_map_vector <= 1'b0;
      o_map_none <= 1'b0;
    end else begin
      o_map_sfr <= i_map_addr <= crf_pkg::SFR_LAST; // RL19 RL20
      o_map_ram <= (i_map_addr >= crf_pkg::RAM_BASE) && (i_map_addr <= RAM_LAST); // RL21
      o_map_dflash <= HAS_DFLASH && (i_map_addr >= crf_pkg::DFL_BASE)
        && (i_map_addr <= crf_pkg::DFL_LAST); // RL24
      o_map_rom <= (i_map_addr >= ROM_FIRST) && (i_map_addr <= crf_pkg::ROM_LAST); // RL22
      o_map_vector <= (i_map_addr >= crf_pkg::VECT_BASE)
        && (i_map_addr <= crf_pkg::ROM_LAST); // RL23
      o_map_none <= !((i_map_addr <= crf_pkg::SFR_LAST)
        || ((i_map_addr >= crf_pkg::RAM_BASE) && (i_map_addr <= RAM_LAST))
        || (HAS_DFLASH && (i_map_addr >= crf_pkg::DFL_BASE)
          && (i_map_addr <= crf_pkg::DFL_LAST))
        || ((i_map_addr >= ROM_FIRST) && (i_map_addr <= crf_pkg::ROM_LAST))); // RL19
    end
  end

endmodule
`default_nettype wire

// >>> crf_cpu_regs_sva.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Port-level checks of the register file
module crf_cpu_regs_chk (
  // Clock, reset and bus handshake
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic o_avs_waitrequest,
  // Flag sources
  input wire logic [3:0] i_alu_flag_we,
  input wire logic [15:0] i_alu_result,
  input wire logic i_alu_result_byte,
  input wire logic i_irq_req,
  input wire logic i_irq_nonmask,
  input wire logic [2:0] i_irq_level,
  input wire logic o_irq_take,
  input wire logic i_swint_exec,
  input wire logic [5:0] i_swint_num,
  input wire logic [10:0] o_flags,
  // Address decode
  input wire logic [19:0] i_map_addr,
  input wire logic o_map_sfr,
  input wire logic o_map_dflash,
  input wire logic o_map_vector
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);

  chk_wait_one: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
    |=> !o_avs_waitrequest) else $error("bus wait state longer than one cycle");
  chk_irq_gate: assert property (
    o_irq_take == (i_irq_req && (i_irq_nonmask || (o_flags[6] && i_irq_level > o_flags[10:8]))))
    else $error("interrupt accept does not follow enable and level");
  chk_irq_clears: assert property (
    o_irq_take |=> o_flags[7:6] == 2'b00) else $error("accept left enable or stack select set");
  chk_swint_clears: assert property (
    i_swint_exec && i_swint_num <= 6'h1f |=> !o_flags[7]) else $error("low swint kept user stack");
  chk_zero_flag: assert property (
    i_alu_flag_we[1] && !i_alu_result_byte |=> o_flags[2] == ($past(i_alu_result) == 16'h0))
    else $error("zero flag wrong");
  chk_sign_flag: assert property (
    i_alu_flag_we[2] && !i_alu_result_byte |=> o_flags[3] == $past(i_alu_result[15]))
    else $error("sign flag wrong");
  chk_map_sfr: assert property (
    i_nrst |=> o_map_sfr == ($past(i_map_addr) <= 20'h002ff)) else $error("sfr decode wrong");
  chk_map_dflash: assert property (
    i_nrst |=> o_map_dflash == ($past(i_map_addr) inside {[20'h02400:20'h02bff]}))
    else $error("data flash decode wrong");
  chk_map_vector: assert property (
    i_nrst |=> o_map_vector == ($past(i_map_addr) inside {[20'h0ffdc:20'h0ffff]}))
    else $error("vector decode wrong");
endmodule

bind crf_cpu_regs crf_cpu_regs_chk chk_u (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_avs_waitrequest(o_avs_waitrequest),
  .i_alu_flag_we(i_alu_flag_we), .i_alu_result(i_alu_result),
  .i_alu_result_byte(i_alu_result_byte), .i_irq_req(i_irq_req), .i_irq_nonmask(i_irq_nonmask),
  .i_irq_level(i_irq_level), .o_irq_take(o_irq_take), .i_swint_exec(i_swint_exec),
  .i_swint_num(i_swint_num), .o_flags(o_flags), .i_map_addr(i_map_addr),
  .o_map_sfr(o_map_sfr), .o_map_dflash(o_map_dflash), .o_map_vector(o_map_vector));
`default_nettype wire

// >>> tb_crf_cpu_regs.sv
`timescale 1ns/100ps
`default_nettype none
module tb_crf_cpu_regs;
  logic clk = 0, nrst = 0, rd = 0, wr = 0, en = 0, wh = 0, req = 0, nmi = 0, sx = 0, rb = 0;
  logic cy = 0, ov = 0, rh = 0;
  logic [3:0] adr = 0, ws = 0, rs = 0, fwe = 0;
  logic [31:0] wd = 0, cd = 0, q, rv;
  logic [31:0] ev [16];
  logic [15:0] res = 0, r16;
  logic [19:0] ma = 0, a;
  logic [2:0] lvl = 0;
  logic [5:0] sn = 0;
  crf_pkg::crf_size_t wz = crf_pkg::SZ_WORD, rz = crf_pkg::SZ_WORD;
  wire [31:0] ard, crd;
  wire [15:0] sp, sbw, fbw;
  wire [19:0] pcw, vbw;
  wire [10:0] processor_flags;
  wire [5:0] mp;
  wire wt, take;
  int seed = 28, num_errors = 0, compares = 0;
  logic [19:0] ca [14] = '{20'h0, 20'h2ff, 20'h300, 20'h400, 20'h7ff, 20'h800, 20'h2400,
    20'h2bff, 20'h2c00, 20'hbfff, 20'hc000, 20'hffdb, 20'hffdc, 20'hfffff};

  // Default sizes: 1 Kbyte RAM, 16 Kbyte ROM, data flash present
  crf_cpu_regs dut_u (.i_ref_clk(clk), .i_nrst(nrst), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'h7), .o_avs_readdata(ard),
    .o_avs_waitrequest(wt), .i_core_wr_en(en), .i_core_wr_sel(ws), .i_core_wr_size(wz),
    .i_core_wr_high(wh), .i_core_wr_data(cd), .i_core_rd_sel(rs), .i_core_rd_size(rz),
    .i_core_rd_high(rh), .o_core_rd_data(crd), .i_alu_flag_we(fwe), .i_alu_carry(cy),
    .i_alu_result(res), .i_alu_result_byte(rb), .i_alu_overflow(ov), .i_irq_req(req),
    .i_irq_nonmask(nmi), .i_irq_level(lvl), .o_irq_take(take), .i_swint_exec(sx),
    .i_swint_num(sn), .o_pc(pcw), .o_vector_base(vbw), .o_active_sp(sp), .o_static_base(sbw),
    .o_frame_base(fbw), .o_flags(processor_flags), .i_map_addr(ma), .o_map_sfr(mp[5]), .o_map_ram(mp[4]),
    .o_map_dflash(mp[3]), .o_map_rom(mp[2]), .o_map_vector(mp[1]), .o_map_none(mp[0]));

  initial forever #12.5 clk = ~clk;

  // ==========================================
  // Helpers
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask

  // Request held until waitrequest is seen low, released after that edge
  task automatic bus(input logic w, input logic [3:0] ad, input logic [31:0] d);
    adr <= ad;
    wd <= d;
    wr <= w;
    rd <= !w;
    do @(posedge clk); while (wt !== 1'b0);
    q = ard;
    wr <= 0;
    rd <= 0;
    @(posedge clk);
  endtask

  task automatic cw(input logic [3:0] s, input crf_pkg::crf_size_t z, input logic h,
                    input logic [31:0] d);
    ws <= s;
    wz <= z;
    wh <= h;
    cd <= d;
    en <= 1;
    @(posedge clk);
    en <= 0;
  endtask

  task automatic cr(input logic [3:0] s, input crf_pkg::crf_size_t z);
    rs <= s;
    rz <= z;
    @(posedge clk);
    @(negedge clk);
    q = crd;
    @(posedge clk);
  endtask

  function automatic logic [31:0] rmask(input int i);
    return (i == 7 || i == 8) ? 32'hfffff : (i > 12 ? 32'h0 : 32'hffff);
  endfunction

  function automatic logic [5:0] emap(input logic [19:0] x);
    logic [4:0] m;
    m = {x <= 20'h002ff, x inside {[20'h00400:20'h007ff]}, x inside {[20'h02400:20'h02bff]},
         x inside {[20'h0c000:20'h0ffff]}, x inside {[20'h0ffdc:20'h0ffff]}};
    return {m, m == 5'h0};
  endfunction

  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    #400000;
    num_errors++;
    report_and_stop();
  end

  // ==========================================
  // Tests
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1;
    @(posedge clk);
    for (int i = 0; i < 16; i++) begin
      ev[i] = $random(seed);
      bus(0, i[3:0], 0);
      chk("reset value", 0, q);
      if (i != 12) bus(1, i[3:0], ev[i]);
    end
    for (int i = 0; i < 16; i++) begin
      if (i != 12) bus(0, i[3:0], 0);
      if (i != 12) chk("readback", ev[i] & rmask(i), q);
    end
    chk("pc port", ev[8] & 32'hfffff, pcw);
    chk("vector port", ev[7] & 32'hfffff, vbw);
    chk("static port", ev[11] & 32'hffff, sbw);
    chk("frame port", ev[6] & 32'hffff, fbw);
    $display("test registers done");
    bus(1, 4'hc, 32'h10);
    bus(0, 4'h0, 0);
    chk("bank one reg", 0, q);
    chk("bank one frame", 0, fbw);
    bus(0, 4'hb, 0);
    chk("shared reg", ev[11] & 32'hffff, q);
    bus(1, 4'h0, 32'h1234);
    bus(1, 4'hc, 0);
    bus(0, 4'h0, 0);
    chk("bank zero reg", ev[0] & 32'hffff, q);
    $display("test banks done");
    bus(1, 4'hc, 32'hf0e5);
    bus(0, 4'hc, 0);
    chk("flag view", 32'h70e5, q & 32'h7fff);
    chk("flag port", 32'h7e5, processor_flags);
    chk("user sp", ev[9] & 32'hffff, sp);
    bus(1, 4'hc, 0);
    chk("irq sp", ev[10] & 32'hffff, sp);
    $display("test flags done");
    rv = $random(seed);
    cw(4'h0, crf_pkg::SZ_LONG, 0, rv);
    cr(4'h2, crf_pkg::SZ_WORD);
    chk("pair upper", rv[31:16], q & 32'hffff);
    cr(4'h0, crf_pkg::SZ_LONG);
    chk("pair whole", rv, q);
    cw(4'h1, crf_pkg::SZ_BYTE, 1, rv);
    cr(4'h1, crf_pkg::SZ_WORD);
    chk("high byte", {rv[7:0], ev[1][7:0]}, q & 32'hffff);
    rh <= 1;
    cr(4'h1, crf_pkg::SZ_BYTE);
    chk("high byte read", rv[7:0], q);
    rh <= 0;
    cw(4'h4, crf_pkg::SZ_LONG, 0, ~rv);
    cr(4'h5, crf_pkg::SZ_WORD);
    chk("addr pair", {16'h0000, ~rv[31:16]}, q & 32'hffff);
    $display("test core port done");
    repeat (24) begin
      rv = $random(seed);
      r16 = rv[21] ? 16'h0 : (rv[20] ? {rv[15:8], 8'h00} : rv[15:0]);
      res <= r16;
      rb <= rv[17];
      cy <= rv[18];
      ov <= rv[19];
      fwe <= 4'hf;
      @(posedge clk);
      fwe <= 0;
      @(negedge clk);
      chk("alu flags", {rv[19], rv[17] ? r16[7] : r16[15],
        rv[17] ? r16[7:0] == 0 : r16 == 0, rv[18]},
        {processor_flags[5], processor_flags[3], processor_flags[2], processor_flags[0]});
      @(posedge clk);
    end
    $display("test alu flags done");
    for (int l = 0; l < 8; l++) begin
      bus(1, 4'hc, 32'h30c0);
      req <= 1;
      lvl <= l[2:0];
      @(negedge clk);
      chk("irq take", l > 3, take);
      @(posedge clk);
      req <= 0;
      @(negedge clk);
      chk("enable and stack", l > 3 ? 0 : 3, processor_flags[7:6]);
      @(posedge clk);
    end
    bus(1, 4'hc, 0);
    req <= 1;
    lvl <= 3'h7;
    @(negedge clk);
    chk("masked block", 0, take);
    @(posedge clk);
    nmi <= 1;
    lvl <= 0;
    @(negedge clk);
    chk("masked take", 1, take);
    @(posedge clk);
    req <= 0;
    nmi <= 0;
    for (int k = 30; k < 34; k++) begin
      bus(1, 4'hc, 32'h80);
      sx <= 1;
      sn <= k[5:0];
      @(posedge clk);
      sx <= 0;
      @(negedge clk);
      chk("swint stack", k > 31, processor_flags[7]);
      @(posedge clk);
    end
    $display("test interrupts done");
    for (int i = 0; i < 40; i++) begin
      rv = $random(seed);
      a = i < 14 ? ca[i] : {i[0] ? 4'h0 : rv[19:16], rv[15:0]};
      ma <= a;
      @(posedge clk);
      @(negedge clk);
      chk("decode", emap(a), mp);
      @(posedge clk);
    end
    $display("test decode done");
    report_and_stop();
  end
endmodule
`default_nettype wire
